// ---- src/flash_host_pkg.sv ----
// constants shared by the parallel flash host controller
package flash_host_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_WDATA = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;
  // ctrl fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_CHECK_BIT = 4;
  // cfg fields
  localparam int CFG_BYTE_BIT = 0;
  localparam int CFG_TEMP_BIT = 1;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_READY = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_IDMODE = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_TIMEOUT = 5;
  localparam int ST_SECT_LSB = 8;
  // operation codes written to ctrl
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_WRITE = 4'h2;
  localparam logic [3:0] OP_HWRST = 4'h3;
  localparam logic [3:0] OP_PROT = 4'h4;
  localparam logic [3:0] OP_UNPROT = 4'h5;
  localparam logic [3:0] OP_VERIFY = 4'h6;
  localparam logic [3:0] OP_ID = 4'h7;
  localparam logic [3:0] OP_POLL = 4'h8;
  // command codes the host tracks
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam int FAIL_BIT = 5;
  // timing
  localparam int CLK_NS = 50;
  localparam int ACC_NS = 70;
  localparam int WE_NS = 50;
  localparam int PROT_NS = 100000;
  localparam int TRP_NS_DEF = 500;
  localparam int TREADY_NS_DEF = 20000;
  localparam int SYNC_LAT = 4;
  localparam logic [11:0] ACC_CYC = 12'((ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] RD_CYC = 12'(ACC_CYC + SYNC_LAT);
  localparam logic [11:0] WE_CYC = 12'((WE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] PROT_CYC = 12'((PROT_NS + CLK_NS - 1) / CLK_NS);
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : flash_host_pkg

// ---- src/flash_pin_sync.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module flash_pin_sync #(
  parameter int W = 17
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous pins and filtered result
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);
  logic [W-1:0] s1_ff; // first stage, read only by s2
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff; // accepted value
  logic [W-1:0] nxt_out;

  // a bit moves only when stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
    end
  end

  // shift chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      out_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign pin_out = out_ff;
endmodule : flash_pin_sync

// ---- src/flash_host.sv ----
// apb-controlled host that drives a parallel boot-sector flash
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module flash_host
  import flash_host_pkg::*;
#(
  parameter int TRP_NS = TRP_NS_DEF, // least clear pulse
  parameter int TREADY_NS = TREADY_NS_DEF // longest abort time
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash control pins
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic clear_n,
  output logic clear_hv,
  output logic a9_hv,
  output logic byte_n,
  output logic [18:0] flash_addr,
  input wire logic ready_busy_n,
  // flash data pins
  input wire logic [14:0] dq_i,
  output logic [14:0] dq_o,
  output logic dq_oe_n,
  input wire logic top_data_or_low_address_i,
  output logic top_data_or_low_address_o,
  output logic top_data_or_low_address_oe_n
);
  // least time rounds up, longest rounds down
  localparam logic [11:0] TRP_CYC = 12'((TRP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] TREADY_CYC = 12'(TREADY_NS / CLK_NS);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SETUP = 3'b001,
    S_ACT = 3'b011,
    S_RECOV = 3'b010,
    S_BUSYW = 3'b110
  } state_t;

  // sector of a bottom-boot part from a18..a12
  function automatic logic [4:0] sector_of(input logic [6:0] a);
    if (a[6:3] != 4'h0) sector_of = 5'(a[6:3]) + 5'h03;
    else if (a[2]) sector_of = 5'h03;
    else if (a[1]) sector_of = 5'(a[0]) + 5'h01;
    else sector_of = 5'h00;
  endfunction : sector_of

  // low byte belongs to the defined command set
  function automatic logic is_cmd(input logic [7:0] d);
    case (d)
      8'haa, 8'h55, 8'h90, 8'ha0, 8'h80, 8'h10,
      8'h30, 8'hb0, 8'h60, 8'h40, 8'hf0: is_cmd = 1'b1;
      default: is_cmd = 1'b0;
    endcase
  endfunction : is_cmd

  // register state
  state_t state_ff, nxt_state;
  logic [3:0] op_ff, nxt_op; // running operation
  logic [11:0] cnt_ff, nxt_cnt; // phase counter
  logic byte_ff, nxt_byte; // byte mode select
  logic temp_ff, nxt_temp; // temporary unprotect level
  logic [19:0] addr_ff, nxt_addr; // array address, byte or word
  logic [15:0] wdata_ff, nxt_wdata;
  logic [15:0] rdata_ff, nxt_rdata;
  logic fail_ff, nxt_fail; // fail flag seen while polling
  logic idm_ff, nxt_idm; // device left in auto-select
  logic refused_ff, nxt_refused; // sticky, write one to clear
  logic timeout_ff, nxt_timeout; // busy outlived abort time
  // registered pin images
  logic ce_ff, oe_ff, we_ff, clr_ff, chv_ff, ahv_ff, drv_ff;
  logic nxt_ce, nxt_oe, nxt_we, nxt_clr, nxt_chv, nxt_ahv, nxt_drv;
  logic [18:0] pa_ff, nxt_pa;
  logic top_ff, nxt_top;

  // synchronised pin inputs
  logic [16:0] sync_q;
  logic rdy_s;
  logic [15:0] dq_s;

  flash_pin_sync #(.W(17)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({ready_busy_n, top_data_or_low_address_i, dq_i}),
    .pin_out(sync_q)
  );
  assign rdy_s = sync_q[16];
  assign dq_s = sync_q[15:0];

  // apb decode
  logic wr_en, rd_en, hit;
  logic [3:0] wop;
  logic is_wr_op, is_hv_w, is_rd_op;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign hit = (paddr == OFS_CTRL) | (paddr == OFS_CFG) |
               (paddr == OFS_ADDR) | (paddr == OFS_WDATA) |
               (paddr == OFS_STATUS) | (paddr == OFS_RDATA);
  assign pready = 1'b1; // zero-wait slave
  assign pslverr = psel & penable & ~hit;
  assign wop = pwdata[CTRL_OP_LSB +: 4];
  assign is_wr_op = (op_ff == OP_WRITE) | is_hv_w;
  assign is_hv_w = (op_ff == OP_PROT) | (op_ff == OP_UNPROT);
  assign is_rd_op = (op_ff == OP_READ) | (op_ff == OP_POLL) |
                    (op_ff == OP_VERIFY) | (op_ff == OP_ID);

  // read mux
  always_comb begin
    prdata = RST_WORD;
    if (rd_en) begin
      case (paddr)
        OFS_CFG: prdata = {30'h0, temp_ff, byte_ff};
        OFS_ADDR: prdata = {12'h0, addr_ff};
        OFS_WDATA: prdata = {16'h0, wdata_ff};
        OFS_STATUS: begin
          prdata[ST_BUSY] = (state_ff != S_IDLE);
          prdata[ST_READY] = rdy_s;
          prdata[ST_FAIL] = fail_ff;
          prdata[ST_IDMODE] = idm_ff;
          prdata[ST_REFUSED] = refused_ff;
          prdata[ST_TIMEOUT] = timeout_ff;
          // sector of current address, a18..a12 per mode
          prdata[ST_SECT_LSB +: 5] = byte_ff ? sector_of(addr_ff[19:13])
                                             : sector_of(addr_ff[18:12]);
        end
        OFS_RDATA: prdata = {16'h0, rdata_ff};
        default: prdata = RST_WORD;
      endcase
    end
  end

  // next-state logic for sequencer, registers and pins
  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_cnt = cnt_ff;
    nxt_byte = byte_ff;
    nxt_temp = temp_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_fail = fail_ff;
    nxt_idm = idm_ff;
    nxt_refused = refused_ff;
    nxt_timeout = timeout_ff;
    // software clears refused by writing one; a new refusal wins
    if (wr_en && paddr == OFS_STATUS && pwdata[ST_REFUSED]) nxt_refused = 1'b0;
    // config and operands only change while idle
    if (wr_en && state_ff == S_IDLE) begin
      case (paddr)
        OFS_CFG: begin
          nxt_byte = pwdata[CFG_BYTE_BIT];
          nxt_temp = pwdata[CFG_TEMP_BIT];
        end
        OFS_ADDR: nxt_addr = pwdata[19:0];
        OFS_WDATA: nxt_wdata = pwdata[15:0];
        default: nxt_addr = addr_ff;
      endcase
    end
    case (state_ff)
      S_IDLE: begin
        if (wr_en && paddr == OFS_CTRL && wop != OP_NONE) begin
          if (wop == OP_READ && (fail_ff || idm_ff)) begin
            nxt_refused = 1'b1;
          end else if (wop == OP_WRITE && pwdata[CTRL_CHECK_BIT] &&
                       !is_cmd(wdata_ff[7:0])) begin
            nxt_refused = 1'b1;
          end else if (wop > OP_POLL) begin
            nxt_refused = 1'b1;
          end else begin
            nxt_op = wop;
            nxt_cnt = 12'h001;
            nxt_state = S_SETUP;
          end
        end else if (wr_en && paddr == OFS_CTRL) begin
          nxt_refused = refused_ff;
        end
      end
      S_SETUP: begin
        // address and ce settle one cycle before the we or clear pulse; reads already drop ce and oe here
        nxt_state = S_ACT;
        if (op_ff == OP_HWRST) nxt_cnt = TRP_CYC;
        else if (is_hv_w) nxt_cnt = PROT_CYC;
        else if (op_ff == OP_WRITE) nxt_cnt = WE_CYC;
        else nxt_cnt = RD_CYC;
      end
      S_ACT: begin
        if (cnt_ff > 12'h001) begin
          nxt_cnt = cnt_ff - 12'h001;
        end else if (op_ff == OP_HWRST) begin
          nxt_cnt = TREADY_CYC;
          nxt_state = S_BUSYW;
        end else begin
          nxt_state = S_RECOV;
          if (is_rd_op) nxt_rdata = dq_s;
          if (op_ff == OP_POLL && dq_s[FAIL_BIT]) nxt_fail = 1'b1;
          // an autoselect write leaves id mode set, a reset write ends it and clears fail
          if (op_ff == OP_WRITE && wdata_ff[7:0] == CMD_AUTOSEL) begin
            nxt_idm = 1'b1;
          end
          if (op_ff == OP_WRITE && wdata_ff[7:0] == CMD_RESET) begin
            nxt_idm = 1'b0;
            nxt_fail = 1'b0;
          end
        end
      end
      S_RECOV: nxt_state = S_IDLE;
      S_BUSYW: begin
        // busy stays low until the abort finishes
        nxt_fail = 1'b0;
        nxt_idm = 1'b0;
        // synced busy lags the pin, so ready counts only after that lag
        if (rdy_s && cnt_ff <= TREADY_CYC - 12'(SYNC_LAT)) begin
          nxt_state = S_IDLE;
        end else if (cnt_ff <= 12'h001) begin
          nxt_timeout = 1'b1;
          nxt_state = S_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 12'h001;
        end
      end
      default: nxt_state = S_IDLE;
    endcase

    // pin images follow the next state
    nxt_ce = 1'b1;
    nxt_oe = 1'b1;
    nxt_we = 1'b1;
    nxt_clr = 1'b1;
    nxt_chv = temp_ff;
    nxt_ahv = 1'b0;
    nxt_drv = 1'b0;
    nxt_pa = byte_ff ? addr_ff[19:1] : addr_ff[18:0];
    nxt_top = addr_ff[0];
    if (nxt_state != S_IDLE) begin
      if (nxt_op == OP_HWRST) begin
        nxt_clr = (nxt_state != S_ACT);
      end else if (nxt_op == OP_WRITE || nxt_op == OP_PROT ||
                   nxt_op == OP_UNPROT) begin
        // we falls after ce, rises first: device latches then
        nxt_ce = 1'b0;
        nxt_we = (nxt_state != S_ACT);
        nxt_drv = 1'b1;
        nxt_top = byte_ff ? addr_ff[0] : wdata_ff[15];
      end else begin
        nxt_ce = (nxt_state == S_RECOV);
        nxt_oe = (nxt_state == S_RECOV);
      end
      if (nxt_op == OP_PROT || nxt_op == OP_UNPROT) begin
        nxt_chv = 1'b1;
        nxt_pa[0] = 1'b0;
        nxt_pa[1] = 1'b1;
        nxt_pa[6] = (nxt_op == OP_UNPROT);
      end
      if (nxt_op == OP_VERIFY || nxt_op == OP_ID) begin
        nxt_ahv = (nxt_state != S_RECOV);
        nxt_pa[1] = (nxt_op == OP_VERIFY);
        if (nxt_op == OP_VERIFY) begin
          nxt_pa[0] = 1'b0;
          nxt_pa[6] = 1'b0;
        end
      end
    end
  end

  // register everything; reset holds the flash in hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= S_IDLE;
      op_ff <= OP_NONE;
      cnt_ff <= 12'h000;
      byte_ff <= 1'b0;
      temp_ff <= 1'b0;
      addr_ff <= 20'h00000;
      wdata_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
      fail_ff <= 1'b0;
      idm_ff <= 1'b0;
      refused_ff <= 1'b0;
      timeout_ff <= 1'b0;
      ce_ff <= 1'b1;
      oe_ff <= 1'b1;
      we_ff <= 1'b1;
      clr_ff <= 1'b0;
      chv_ff <= 1'b0;
      ahv_ff <= 1'b0;
      drv_ff <= 1'b0;
      pa_ff <= 19'h00000;
      top_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      cnt_ff <= nxt_cnt;
      byte_ff <= nxt_byte;
      temp_ff <= nxt_temp;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      fail_ff <= nxt_fail;
      idm_ff <= nxt_idm;
      refused_ff <= nxt_refused;
      timeout_ff <= nxt_timeout;
      ce_ff <= nxt_ce;
      oe_ff <= nxt_oe;
      we_ff <= nxt_we;
      clr_ff <= nxt_clr;
      chv_ff <= nxt_chv;
      ahv_ff <= nxt_ahv;
      drv_ff <= nxt_drv;
      pa_ff <= nxt_pa;
      top_ff <= nxt_top;
    end
  end

  // pin outputs straight from flops
  assign ce_n = ce_ff;
  assign oe_n = oe_ff;
  assign we_n = we_ff;
  assign clear_n = clr_ff;
  assign clear_hv = chv_ff;
  assign a9_hv = ahv_ff;
  assign byte_n = ~byte_ff;
  assign flash_addr = pa_ff;
  assign dq_o = wdata_ff[14:0];
  assign dq_oe_n = ~drv_ff;
  assign top_data_or_low_address_o = top_ff;
  // in byte mode the top pin is always an address output
  assign top_data_or_low_address_oe_n = ~(drv_ff | byte_ff);
endmodule : flash_host

// ---- test/flash_dev_model.sv ----
// pin-level model of the boot-sector flash
`timescale 1ns/10ps
module flash_dev_model #(
  parameter logic [15:0] MAKER_ID = 16'h0a11, // arbitrary value
  parameter logic [15:0] DEV_ID = 16'h0b22, // arbitrary value
  parameter int RB_NS = 200, // prompt abort
  parameter int RB_SLOW_NS = 900, // longer than the host waits
  parameter logic [15:0] ERS_STAT = 16'h00a4 // status word, fail bit set
) (
  // control pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic clear_n,
  input wire logic clear_hv,
  input wire logic a9_hv,
  input wire logic byte_n,
  input wire logic slow,
  // address and data
  input wire logic [18:0] addr,
  input wire logic [15:0] dq,
  output logic [15:0] q,
  output logic ready_busy_n
);
  logic [15:0] mem [int]; // programmed words only
  logic [18:0] prot = '0; // one protect bit a sector
  logic idmode = 1'b0; // id read mode
  logic [18:0] ers = '0; // sectors picked for erase
  logic susp = 1'b0; // erase held by suspend
  logic act = 1'b0; // write cycle open
  logic [18:0] la; // latched address
  logic [15:0] hold = '0; // last value driven
  logic en; // outputs enabled
  // sector from a18..a12, small sectors at the bottom
  function automatic int sect(input logic [18:0] a);
    if (a[18:15] != 4'h0) return 3 + int'(a[18:15]);
    if (a[14]) return 3;
    return a[13] ? 1 + int'(a[12]) : 0;
  endfunction : sect
  initial ready_busy_n = 1'b1;
  // clear drops id mode, busy until the abort ends
  always @(negedge clear_n) begin
    idmode = 1'b0;
    ready_busy_n = 1'b0;
  end
  always @(posedge clear_n) begin
    #(slow ? RB_SLOW_NS : RB_NS);
    ready_busy_n = 1'b1;
  end
  // address at the later fall, oe low inhibits
  always @(negedge ce_n or negedge we_n) begin
    if (!ce_n && !we_n && oe_n) begin
      la = addr;
      act = 1'b1;
    end
  end
  // data at the earlier rise
  always @(posedge ce_n or posedge we_n) begin
    if (act) begin
      act = 1'b0;
      if (clear_hv && !la[0] && la[1]) begin
        if (la[6]) prot = '0;
        else prot[sect(la)] = 1'b1;
      end
      else if (dq[7:0] == 8'hf0) idmode = 1'b0;
      else if (dq[7:0] == 8'h90) idmode = 1'b1;
      else if (dq[7:0] == 8'h30) ers[sect(la)] = 1'b1; // erase start
      else if (dq[7:0] == 8'hb0) susp = |ers;
      else if ((!prot[sect(la)] || clear_hv) && !ers[sect(la)]) begin
        mem[int'(la)] = dq;
      end
    end
  end
  assign en = !ce_n && !oe_n && we_n && clear_n;
  // released lines show the inverse, never the last value
  always @(*) begin
    if (!en) q = ~hold;
    else if (a9_hv && addr[1]) q = {15'h0000, prot[sect(addr)]};
    else if (a9_hv || idmode) q = addr[0] ? DEV_ID : MAKER_ID;
    else if (susp && ers[sect(addr)]) q = ERS_STAT;
    else if (!byte_n) q = {~hold[15:8], addr[6:0], dq[15]};
    else if (mem.exists(int'(addr))) q = mem[int'(addr)];
    else q = {addr[7:0], ~addr[7:0]};
  end
  always @(q) if (en && byte_n) hold = q;
endmodule : flash_dev_model

// ---- test/flash_host_asserts.sv ----
// pin checker for the flash host
`timescale 1ns/10ps
module flash_host_asserts
  import flash_host_pkg::*;
#(
  parameter int TRP_NS = TRP_NS_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // flash pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic clear_n,
  input wire logic a9_hv,
  input wire logic byte_n,
  input wire logic [18:0] flash_addr,
  input wire logic ready_busy_n,
  input wire logic [14:0] dq_o,
  input wire logic dq_oe_n,
  input wire logic top_data_or_low_address_oe_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [15:0] clr_cnt_ff, nxt_clr_cnt; // clear low length
  // saturates; reset value lets the first release pass
  always_comb begin
    nxt_clr_cnt = 16'h0000;
    if (!clear_n && clr_cnt_ff != 16'hffff) nxt_clr_cnt = clr_cnt_ff + 16'h1;
    else if (!clear_n) nxt_clr_cnt = clr_cnt_ff;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) clr_cnt_ff <= 16'hffff;
    else clr_cnt_ff <= nxt_clr_cnt;
  end
  sequence s_wr_hold;
    !ce_n && $stable(flash_addr) && $stable(dq_o);
  endsequence
  sequence s_rd_hold;
    !oe_n && !ce_n && we_n && $stable(flash_addr);
  endsequence
  property p_wr_hold;
    !we_n |-> s_wr_hold ##1 s_wr_hold;
  endproperty
  property p_rd_len;
    $fell(oe_n) |-> ##1 s_rd_hold [*6] ##1 (oe_n && ce_n);
  endproperty
  property p_rd_pins;
    !oe_n |-> we_n && clear_n;
  endproperty
  property p_wr_pins;
    !we_n |-> oe_n && !ce_n;
  endproperty
  property p_no_fight;
    !dq_oe_n |-> oe_n;
  endproperty
  property p_clr_len;
    $rose(clear_n) |-> clr_cnt_ff >= 16'(TRP_NS / CLK_NS);
  endproperty
  property p_busy_idle;
    !ready_busy_n |-> ce_n;
  endproperty
  property p_byte_top;
    !byte_n |-> !top_data_or_low_address_oe_n;
  endproperty
  property p_hv_read;
    a9_hv && !oe_n |-> !ce_n && we_n;
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write pulse framing broken");
  a_rd_len: assert property (p_rd_len)
    else $error("read cycle length or hold wrong");
  a_rd_pins: assert property (p_rd_pins)
    else $error("read with write strobe or clear low");
  a_wr_pins: assert property (p_wr_pins)
    else $error("write strobe without select or with oe");
  a_no_fight: assert property (p_no_fight)
    else $error("host drives data while flash outputs");
  a_clr_len: assert property (p_clr_len)
    else $error("clear pulse too short");
  a_busy_idle: assert property (p_busy_idle)
    else $error("chip selected while busy");
  a_byte_top: assert property (p_byte_top)
    else $error("low address pin not driven in byte mode");
  a_hv_read: assert property (p_hv_read)
    else $error("high voltage read pattern wrong");
endmodule : flash_host_asserts
bind flash_host flash_host_asserts #(.TRP_NS(TRP_NS)) u_chk (
  .pclk, .presetn, .ce_n, .oe_n, .we_n, .clear_n, .a9_hv, .byte_n,
  .flash_addr, .ready_busy_n, .dq_o, .dq_oe_n,
  .top_data_or_low_address_oe_n
);

// ---- test/parallel_flash_bus_and_protection_tb_top.sv ----
// bench: apb flash host against the pin-level flash model
`timescale 1ns/10ps
module parallel_flash_bus_and_protection_tb_top import flash_host_pkg::*;;
  localparam logic [15:0] MID = 16'h0a11; // arbitrary value
  localparam logic [15:0] DID = 16'h0b22; // arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ce_n, oe_n, we_n, clear_n, clear_hv, a9_hv, byte_n, ready_busy_n;
  logic [18:0] flash_addr;
  logic [14:0] dq_i, dq_o;
  logic dq_oe_n, top_data_or_low_address_i, top_data_or_low_address_o;
  logic top_data_or_low_address_oe_n;
  logic [15:0] q;
  logic [31:0] pa [4] = '{32'h01ff0, 32'h02000, 32'h02ff0, 32'h03000};
  logic [3:0] pe = 4'b0110; // protected entries of pa
  int err_total = 0;
  int n_compared = 0;
  // wire level: host wins where it drives
  assign dq_i = !dq_oe_n ? dq_o : q[14:0];
  assign top_data_or_low_address_i = !top_data_or_low_address_oe_n ?
    top_data_or_low_address_o : q[15];
  flash_host #(.TRP_NS(100), .TREADY_NS(500)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ce_n, .oe_n, .we_n, .clear_n, .clear_hv, .a9_hv,
    .byte_n, .flash_addr, .ready_busy_n, .dq_i, .dq_o, .dq_oe_n,
    .top_data_or_low_address_i, .top_data_or_low_address_o,
    .top_data_or_low_address_oe_n
  );
  flash_dev_model #(.MAKER_ID(MID), .DEV_ID(DID)) u_dev (
    .ce_n, .oe_n, .we_n, .clear_n, .clear_hv, .a9_hv, .byte_n, .slow,
    .addr(flash_addr), .dq({top_data_or_low_address_i, dq_i}), .q,
    .ready_busy_n
  );
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // start an operation and poll busy with a bound
  task automatic op(input logic [3:0] o, input logic cb);
    apb(1'b1, OFS_CTRL, {27'h0, cb, o});
    for (int i = 0; i < 3000; i++) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      if (rd[ST_BUSY] === 1'b0) break;
    end
  endtask : op
  task automatic frd(input logic [31:0] a, input logic [3:0] o);
    apb(1'b1, OFS_ADDR, a);
    op(o, 1'b0);
    apb(1'b0, OFS_RDATA, 32'h0);
  endtask : frd
  task automatic fwr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, OFS_ADDR, a);
    apb(1'b1, OFS_WDATA, d);
    op(OP_WRITE, 1'b0);
  endtask : fwr
  task automatic finish_test();
    if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // watchdog well past the expected run
  initial begin
    #1000000;
    err_total++;
    finish_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    repeat (2) @(posedge pclk);
    chk(clear_n, 1'b0);
    presetn <= 1'b1;
    for (int i = 0; i < 99 && rd[ST_READY] !== 1'b1; i++)
      apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_READY], 1'b1);
    frd(32'h00040, OP_READ);
    chk(rd[15:0], 16'h40bf);
    fwr(32'h00040, 32'h1234);
    fwr(32'h00041, 32'hfedc);
    frd(32'h00040, OP_READ);
    chk(rd[15:0], 16'h1234);
    frd(32'h00041, OP_READ);
    chk(rd[15:0], 16'hfedc);
    apb(1'b1, OFS_ADDR, 32'h02000);
    op(OP_PROT, 1'b0);
    for (int i = 0; i < 4; i++) begin
      frd(pa[i], OP_VERIFY);
      chk(rd[7:0], {7'h0, pe[i]});
    end
    fwr(32'h02010, 32'h0abc);
    frd(32'h02010, OP_READ);
    chk(rd[15:0], 16'h10ef);
    apb(1'b1, OFS_CFG, 32'h2);
    fwr(32'h02010, 32'h0abc);
    chk(clear_hv, 1'b1);
    frd(32'h02010, OP_READ);
    chk(rd[15:0], 16'h0abc);
    apb(1'b1, OFS_CFG, 32'h0);
    op(OP_HWRST, 1'b0);
    chk(rd[ST_TIMEOUT], 1'b0);
    frd(32'h02000, OP_VERIFY);
    chk(rd[7:0], 8'h01);
    op(OP_UNPROT, 1'b0);
    frd(32'h02000, OP_VERIFY);
    chk(rd[7:0], 8'h00);
    frd(32'h0, OP_ID);
    chk(rd[15:0], MID);
    frd(32'h1, OP_ID);
    chk(rd[15:0], DID);
    apb(1'b1, OFS_WDATA, 32'h90);
    op(OP_WRITE, 1'b1);
    chk(rd[ST_IDMODE], 1'b1);
    frd(32'h00040, OP_READ);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_REFUSED], 1'b1);
    apb(1'b1, OFS_STATUS, 32'h10);
    apb(1'b1, OFS_WDATA, 32'h77);
    op(OP_WRITE, 1'b1);
    chk(rd[ST_REFUSED], 1'b1);
    apb(1'b1, OFS_WDATA, 32'hf0);
    op(OP_WRITE, 1'b1);
    chk(rd[ST_IDMODE], 1'b0);
    frd(32'h00040, OP_READ);
    chk(rd[15:0], 16'h1234);
    apb(1'b0, 8'h18, 32'h0);
    chk(perr, 1'b1);
    fwr(32'h08000, 32'h30);
    fwr(32'h08000, 32'hb0);
    chk(rd[ST_SECT_LSB +: 5], 5'h04);
    frd(32'h08010, OP_POLL);
    chk(rd[15:0], 16'h00a4);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_FAIL], 1'b1);
    apb(1'b1, OFS_STATUS, 32'h10);
    op(4'h9, 1'b0);
    chk(rd[ST_REFUSED], 1'b1);
    apb(1'b1, OFS_STATUS, 32'h10);
    frd(32'h00040, OP_READ);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_REFUSED], 1'b1);
    apb(1'b1, OFS_WDATA, 32'hf0);
    op(OP_WRITE, 1'b1);
    chk(rd[ST_FAIL], 1'b0);
    fwr(32'h00050, 32'h5555);
    frd(32'h00050, OP_READ);
    chk(rd[15:0], 16'h5555);
    frd(32'h00040, OP_READ);
    chk(rd[15:0], 16'h1234);
    apb(1'b1, OFS_CFG, 32'h1);
    frd(32'h00021, OP_READ);
    chk(rd[7:0], 8'h21);
    apb(1'b1, OFS_CFG, 32'h0);
    slow <= 1'b1;
    op(OP_HWRST, 1'b0);
    chk(rd[ST_TIMEOUT], 1'b1);
    finish_test();
  end
endmodule : parallel_flash_bus_and_protection_tb_top
